// ### timer_ctrl_regs.svh
// register map, field positions and reset values of the dual timer mode control
// Contract
// - timer 1 mode field 00 selects a 13-bit, 01 a 16-bit and 10 an 8-bit auto-reload count.
// - timer 1 mode field 11 holds timer 1 inactive so that it never counts.
// - with gate control clear, timer 0 is enabled whenever its run bit is 1.
// - with gate control set, timer 0 runs only while run is 1 and the ext_interrupt0_input input is active.
// - with counter select clear, timer 0 counts the clock picked by its clock select bit.
// - with counter select set, timer 0 counts each falling edge on its count pin.
// - timer 0 mode is the two-bit field in bits 1 to 0 of the timer mode register.
// - timer 1 mode is the two-bit field in bits 5 to 4 of the same register.
`ifndef TIMER_CTRL_REGS_SVH
`define TIMER_CTRL_REGS_SVH

`define ADDR_W 8
`define OFS_TIMER_MODE 8'h00
`define OFS_RUN_CTRL 8'h04
`define OFS_CLOCK_CTRL 8'h08
`define OFS_EXT_INT_CFG 8'h0c
`define OFS_STATUS 8'h10

`define TMOD_T0_MODE_LSB 0
`define TMOD_T0_MODE_MSB 1
`define TMOD_T0_COUNTER_SEL 2
`define TMOD_T0_GATE 3
`define TMOD_T1_MODE_LSB 4
`define TMOD_T1_MODE_MSB 5
`define TMOD_WIDTH 6

`define RUN_T0_BIT 0
`define RUN_T1_BIT 1
`define CLK_T0_SEL_BIT 2
`define INT_T0_POL_BIT 0

`define STAT_T0_EN_BIT 0
`define STAT_T1_EN_BIT 1
`define STAT_T0_MODE_LSB 2
`define STAT_T1_MODE_LSB 4
`define STAT_EXT_INTERRUPT0_INPUT_ACT_BIT 6
`define STAT_PIN_BIT 7

`define RST_TIMER_MODE 6'h00
`define RST_RUN 2'h0
`define RST_BIT 1'b0
`define RST_PIN_PREV 1'b1
`define RST_WORD 32'h0000_0000
`define HRESP_OKAY 1'b0
`define HTRANS_NONSEQ_BIT 1

`endif

// ### timer_ctrl_pkg.sv
// types shared by the dual timer mode control modules
package timer_ctrl_pkg;

   typedef enum logic [1:0] {
      mode_13bit,
      mode_16bit,
      mode_8bit_reload,
      mode_inactive
   } count_mode_t;

   typedef struct packed {
      logic [5:0] timer_mode;
      logic [1:0] run;
      logic timer0_clock_select;
      logic ext_ext_interrupt0_input_polarity;
      logic wr_pending;
      logic [7:0] wr_addr;
      logic [31:0] hrdata;
      logic hreadyout;
      logic hresp;
      logic timer0_enable;
      logic timer1_enable;
      logic timer0_increment;
      count_mode_t timer0_mode;
      count_mode_t timer1_mode;
   } ctrl_state_t;

   typedef struct packed {
      logic pin_prev;
      logic fall;
   } edge_state_t;

endpackage : timer_ctrl_pkg

// ### mode_field_decode.sv
// two-bit timer mode field decoder
`timescale 1ns/1ps
module mode_field_decode #(
   parameter bit HOLD_ON_MODE3 = 1'b1
) (
   // field
   input wire logic [1:0] mode_field,
   // decoded
   output timer_ctrl_pkg::count_mode_t mode,
   output logic counts
);
   import timer_ctrl_pkg::*;

   always_comb begin
      unique case (mode_field)
         2'h0: mode = mode_13bit;
         2'h1: mode = mode_16bit;
         2'h2: mode = mode_8bit_reload;
         2'h3: mode = mode_inactive;
      endcase
      // mode 3 stops timer 1 only; timer 0 keeps counting there
      counts = !(HOLD_ON_MODE3 && (mode_field == 2'h3));
   end
endmodule : mode_field_decode

// ### fall_edge_detect.sv
// falling-edge detector for the timer 0 count pin
`timescale 1ns/1ps
`include "timer_ctrl_regs.svh"
module fall_edge_detect (
   // clock and reset
   input wire logic hclk,
   input wire logic hresetn,
   // pin
   input wire logic pin,
   // one-cycle pulse on each high-to-low step
   output logic fall
);
   import timer_ctrl_pkg::*;

   edge_state_t s;
   edge_state_t next_s;

   always_comb begin
      next_s = s;
      next_s.pin_prev = pin;
      next_s.fall = s.pin_prev && !pin;
   end

   // prev resets to the pin's idle high level; a pin held low through reset
   // shows one false fall, so the pin must idle high while reset is low
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         s <= '{pin_prev: `RST_PIN_PREV, fall: `RST_BIT};
      end else begin
         s <= next_s;
      end
   end

   assign fall = s.fall;
endmodule : fall_edge_detect

// ### timer_mode_ctrl.sv
// ahb-lite register slave and mode/gate control for two counter/timers
`timescale 1ns/1ps
`include "timer_ctrl_regs.svh"
module timer_mode_ctrl (
   // clock and reset
   input wire logic hclk,
   input wire logic hresetn,
   // ahb-lite slave
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic [31:0] hrdata,
   output logic hreadyout,
   output logic hresp,
   // timer pins and clock sources
   input wire logic ext_interrupt0_input,
   input wire logic timer0_count_pin,
   input wire logic prescaled_tick,
   // to the counting datapaths
   output logic timer0_enable,
   output logic timer0_increment,
   output timer_ctrl_pkg::count_mode_t timer0_mode,
   output logic timer1_enable,
   output timer_ctrl_pkg::count_mode_t timer1_mode
);
   import timer_ctrl_pkg::*;

   localparam bit [1:0] HOLD_ON_MODE3 = 2'b10;

   ctrl_state_t s;
   ctrl_state_t next_s;

   logic count_fall;
   logic [1:0] mode_field [2];
   count_mode_t dec_mode [2];
   logic dec_counts [2];
   logic ext_interrupt0_input_active;
   logic timer0_gate_ok;
   logic timer0_tick;
   logic addr_phase;
   logic [31:0] rd_word;

   fall_edge_detect u_fall (
      .hclk(hclk),
      .hresetn(hresetn),
      .pin(timer0_count_pin),
      .fall(count_fall)
   );

   // decode from the value being written so modes follow a write at once
   assign mode_field[0] = next_s.timer_mode[`TMOD_T0_MODE_MSB:`TMOD_T0_MODE_LSB];
   assign mode_field[1] = next_s.timer_mode[`TMOD_T1_MODE_MSB:`TMOD_T1_MODE_LSB];

   genvar gi;
   generate
      for (gi = 0; gi < 2; gi++) begin : g_dec
         mode_field_decode #(
            .HOLD_ON_MODE3(HOLD_ON_MODE3[gi])
         ) u_dec (
            .mode_field(mode_field[gi]),
            .mode(dec_mode[gi]),
            .counts(dec_counts[gi])
         );
      end
   endgenerate

   always_comb begin
      next_s = s;
      addr_phase = hsel && hready && htrans[`HTRANS_NONSEQ_BIT];

      // data phase of a write: store into the addressed register
      next_s.wr_pending = addr_phase && hwrite;
      if (addr_phase) begin
         next_s.wr_addr = haddr[`ADDR_W-1:0];
      end
      if (s.wr_pending) begin
         unique case (s.wr_addr)
            `OFS_TIMER_MODE: begin
               next_s.timer_mode = hwdata[`TMOD_WIDTH-1:0];
            end
            `OFS_RUN_CTRL: begin
               next_s.run[0] = hwdata[`RUN_T0_BIT];
               next_s.run[1] = hwdata[`RUN_T1_BIT];
            end
            `OFS_CLOCK_CTRL: begin
               next_s.timer0_clock_select = hwdata[`CLK_T0_SEL_BIT];
            end
            `OFS_EXT_INT_CFG: begin
               next_s.ext_ext_interrupt0_input_polarity = hwdata[`INT_T0_POL_BIT];
            end
            default: begin
            end
         endcase
      end

      // polarity 1 means active high, 0 active low
      ext_interrupt0_input_active = next_s.ext_ext_interrupt0_input_polarity ? ext_interrupt0_input : !ext_interrupt0_input;
      // gate clear ignores ext_interrupt0_input; gate set needs it active
      timer0_gate_ok = !next_s.timer_mode[`TMOD_T0_GATE] || ext_interrupt0_input_active;
      next_s.timer0_enable = next_s.run[0] && timer0_gate_ok && dec_counts[0];
      next_s.timer1_enable = next_s.run[1] && dec_counts[1];
      next_s.timer0_mode = dec_mode[0];
      next_s.timer1_mode = dec_mode[1];

      // clock select 1 counts every system clock, 0 the prescaled tick
      if (next_s.timer_mode[`TMOD_T0_COUNTER_SEL]) begin
         timer0_tick = count_fall;
      end else begin
         timer0_tick = next_s.timer0_clock_select ? 1'b1 : prescaled_tick;
      end
      next_s.timer0_increment = next_s.timer0_enable && timer0_tick;

      // control register read data reflects a write completing in the same cycle; status enables and modes read the registered outputs
      rd_word = `RST_WORD;
      unique case (haddr[`ADDR_W-1:0])
         `OFS_TIMER_MODE: begin
            rd_word[`TMOD_WIDTH-1:0] = next_s.timer_mode;
         end
         `OFS_RUN_CTRL: begin
            rd_word[`RUN_T0_BIT] = next_s.run[0];
            rd_word[`RUN_T1_BIT] = next_s.run[1];
         end
         `OFS_CLOCK_CTRL: begin
            rd_word[`CLK_T0_SEL_BIT] = next_s.timer0_clock_select;
         end
         `OFS_EXT_INT_CFG: begin
            rd_word[`INT_T0_POL_BIT] = next_s.ext_ext_interrupt0_input_polarity;
         end
         `OFS_STATUS: begin
            rd_word[`STAT_T0_EN_BIT] = s.timer0_enable;
            rd_word[`STAT_T1_EN_BIT] = s.timer1_enable;
            rd_word[`STAT_T0_MODE_LSB +: 2] = s.timer0_mode;
            rd_word[`STAT_T1_MODE_LSB +: 2] = s.timer1_mode;
            rd_word[`STAT_EXT_INTERRUPT0_INPUT_ACT_BIT] = ext_interrupt0_input_active;
            rd_word[`STAT_PIN_BIT] = timer0_count_pin;
         end
         default: begin
         end
      endcase
      if (addr_phase && !hwrite) begin
         next_s.hrdata = rd_word;
      end
      // zero-wait slave, always OKAY
      next_s.hreadyout = 1'b1;
      next_s.hresp = `HRESP_OKAY;
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         s <= '{timer_mode: `RST_TIMER_MODE, run: `RST_RUN,
                timer0_clock_select: `RST_BIT, ext_ext_interrupt0_input_polarity: `RST_BIT,
                wr_pending: 1'b0, wr_addr: '0, hrdata: `RST_WORD,
                hreadyout: 1'b1, hresp: `HRESP_OKAY,
                timer0_enable: 1'b0, timer1_enable: 1'b0, timer0_increment: 1'b0,
                timer0_mode: mode_13bit, timer1_mode: mode_13bit};
      end else begin
         s <= next_s;
      end
   end

   assign hrdata = s.hrdata;
   assign hreadyout = s.hreadyout;
   assign hresp = s.hresp;
   assign timer0_enable = s.timer0_enable;
   assign timer0_increment = s.timer0_increment;
   assign timer0_mode = s.timer0_mode;
   assign timer1_enable = s.timer1_enable;
   assign timer1_mode = s.timer1_mode;
endmodule : timer_mode_ctrl

// ### timer_mode_checker.sv
// port assertions for the timer mode control
`timescale 1ns/1ps
module timer_mode_checker
   import timer_ctrl_pkg::*;
(
   // clock and reset
   input wire logic hclk,
   input wire logic hresetn,
   // bus
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   input wire logic hreadyout,
   input wire logic hresp,
   // timer side
   input wire logic ext_interrupt0_input,
   input wire logic timer0_count_pin,
   input wire logic prescaled_tick,
   input wire logic timer0_enable,
   input wire logic timer0_increment,
   input count_mode_t timer0_mode,
   input wire logic timer1_enable,
   input count_mode_t timer1_mode
);
   logic wp;
   logic [7:0] wa;
   logic [5:0] tm;
   logic r0;
   logic cs;
   logic pl;
   // shadow copy of the control bits, so outputs can be tied to bus writes
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         wp <= 1'b0;
         wa <= 8'h00;
         tm <= 6'h00;
         r0 <= 1'b0;
         cs <= 1'b0;
         pl <= 1'b0;
      end else begin
         wp <= hsel && hready && htrans[1] && hwrite;
         wa <= haddr[7:0];
         if (wp && wa == 8'h00) tm <= hwdata[5:0];
         if (wp && wa == 8'h04) r0 <= hwdata[0];
         if (wp && wa == 8'h08) cs <= hwdata[2];
         if (wp && wa == 8'h0c) pl <= hwdata[0];
      end
   end
   default clocking @(posedge hclk); endclocking
   default disable iff (!hresetn);
   sequence s_fall;
      timer0_count_pin ##1 !timer0_count_pin;
   endsequence
   property p_t1_mode; timer1_mode == tm[5:4]; endproperty
   a_t1_mode: assert property (p_t1_mode) else $error("timer 1 mode wrong");
   property p_t1_off; timer1_mode == mode_inactive |-> !timer1_enable; endproperty
   a_t1_off: assert property (p_t1_off) else $error("timer 1 runs in mode 3");
   property p_gate_off; !tm[3] |-> timer0_enable == r0; endproperty
   a_gate_off: assert property (p_gate_off) else $error("ungated enable wrong");
   property p_gate_on;
      tm[3] |-> timer0_enable == (r0 && ($past(ext_interrupt0_input) == pl));
   endproperty
   a_gate_on: assert property (p_gate_on) else $error("gated enable wrong");
   property p_src;
      !tm[2] && $stable(tm) && $stable(cs) && timer0_enable && $past(timer0_enable)
         |-> timer0_increment == (cs || $past(prescaled_tick));
   endproperty
   a_src: assert property (p_src) else $error("timer increment wrong");
   property p_pin;
      s_fall ##2 (tm[2] && $past(tm[2]) && timer0_enable && $past(timer0_enable))
         |-> timer0_increment;
   endproperty
   a_pin: assert property (p_pin) else $error("pin fall not counted");
   property p_t0_mode; timer0_mode == tm[1:0]; endproperty
   a_t0_mode: assert property (p_t0_mode) else $error("timer 0 mode wrong");
   property p_okay; hreadyout && !hresp; endproperty
   a_okay: assert property (p_okay) else $error("bus not ready or error");
endmodule : timer_mode_checker

bind timer_mode_ctrl timer_mode_checker i_chk (.hclk, .hresetn, .hsel, .haddr, .htrans,
   .hwrite, .hwdata, .hready, .hreadyout, .hresp, .ext_interrupt0_input, .timer0_count_pin,
   .prescaled_tick, .timer0_enable, .timer0_increment, .timer0_mode, .timer1_enable,
   .timer1_mode);

// ### dual_timer_mode_control_test.sv
// self-checking bench for the timer mode control
`timescale 1ns/1ps
`define CHK(a, b) begin total_checks++; if ((a) !== (b)) begin failures++; \
   $display("unexpected at %0t: %h expected %h", $time, a, b); end end
module dual_timer_mode_control_test;
   import timer_ctrl_pkg::*;
   logic hclk = 1'b0;
   logic hresetn = 1'b0;
   logic hsel = 1'b0;
   logic hwrite = 1'b0;
   logic ext = 1'b0;
   // count pin idles high, as the edge detector expects after reset
   logic pin = 1'b1;
   logic tick = 1'b0;
   logic [1:0] htrans = 2'h0;
   logic [31:0] haddr = 32'h0;
   logic [31:0] hwdata = 32'h0;
   logic [31:0] hrdata, rv, r;
   logic hready, hresp, t0en, t0inc, t1en;
   count_mode_t t0m, t1m;
   logic [5:0] tm = 6'h00;
   logic [1:0] run = 2'h0;
   logic cs = 1'b0;
   logic pl = 1'b0;
   logic [3:0] h = 4'hf;
   int failures = 0, total_checks = 0, cyc = 0;

   timer_mode_ctrl i_dut (
      .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
      .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
      .hreadyout(hready), .hresp(hresp), .ext_interrupt0_input(ext),
      .timer0_count_pin(pin), .prescaled_tick(tick), .timer0_enable(t0en),
      .timer0_increment(t0inc), .timer0_mode(t0m), .timer1_enable(t1en), .timer1_mode(t1m)
   );

   initial forever #50 hclk = ~hclk;

   always @(posedge hclk) begin
      cyc++;
      if (cyc == 4000) begin
         failures++;
         tally_and_finish();
      end
   end

   task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
      hsel <= 1'b1;
      haddr <= {24'h0, a};
      htrans <= 2'h2;
      hwrite <= w;
      do @(posedge hclk); while (hready !== 1'b1);
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= d;
      do @(posedge hclk); while (hready !== 1'b1);
      rv = hrdata;
   endtask : bus

   // model follows every write; unmapped offsets leave it alone
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      bus(1'b1, a, d);
      case (a)
         8'h00: tm = d[5:0];
         8'h04: run = d[1:0];
         8'h08: cs = d[2];
         8'h0c: pl = d[0];
         default: ;
      endcase
   endtask : wr

   task automatic rd_chk(input logic [7:0] a, input logic [31:0] e);
      bus(1'b0, a, 32'h0);
      `CHK(rv, e)
   endtask : rd_chk

   task automatic tally_and_finish();
      $display("checks %0d failures %0d", total_checks, failures);
      if (failures == 0 && total_checks > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask : tally_and_finish

   initial begin
      void'($urandom(14342));
      repeat (5) @(posedge hclk);
      hresetn <= 1'b1;
      @(posedge hclk);
      for (int a = 0; a < 24; a += 4) begin
         // status reads the live ext_interrupt0_input active state (after polarity) and count pin
         rd_chk(a[7:0], (a == 16) ? {24'h0, pin, ext ~^ pl, 6'h00} : 32'h0);
      end
      wr(8'h14, 32'hffff_ffff);
      rd_chk(8'h00, 32'h0);
      $display("test reset done");
      wr(8'h04, 32'h3);
      for (int m = 0; m < 4; m++) begin
         wr(8'h00, 32'(m * 17));
         rd_chk(8'h00, 32'(m * 17));
         rd_chk(8'h10, {24'h0, pin, ext ~^ pl, 2'(m), 2'(m), m != 3, 1'b1});
         @(negedge hclk);
         `CHK(t1m, count_mode_t'(m))
         `CHK(t1en, m != 3)
         `CHK(t0m, count_mode_t'(m))
         `CHK(t0en, 1'b1)
         @(posedge hclk);
      end
      $display("test modes done");
      for (int i = 0; i < 16; i++) begin
         r = $urandom;
         wr(8'h00, r & 32'h8);
         wr(8'h0c, (r >> 4) & 32'h1);
         wr(8'h04, ((r >> 5) & 32'h1) | 32'h2);
         ext <= r[6];
         @(posedge hclk);
         @(negedge hclk);
         `CHK(t0en, run[0] & (~tm[3] | (ext ~^ pl)))
         @(posedge hclk);
      end
      $display("test gate done");
      wr(8'h00, 32'h0);
      wr(8'h04, 32'h1);
      for (int c = 0; c < 2; c++) begin
         wr(8'h08, 32'(c * 4));
         for (int i = 0; i < 12; i++) begin
            tick <= 1'($urandom);
            @(posedge hclk);
            @(negedge hclk);
            `CHK(t0inc, cs | tick)
            @(posedge hclk);
         end
      end
      tick <= 1'b0;
      $display("test source done");
      // pin pipeline: sampled one edge late, then edge register, then output
      wr(8'h00, 32'h4);
      @(posedge hclk);
      for (int i = 0; i < 40; i++) begin
         r = $urandom;
         pin <= r[0];
         @(negedge hclk);
         `CHK(t0inc, h[2] & ~h[1])
         h = {h[2:0], r[0]};
         @(posedge hclk);
      end
      $display("test count pin done");
      tally_and_finish();
   end
endmodule : dual_timer_mode_control_test
